// file: shared/nfc_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the flash bus controller
// Assumes: 20 MHz system clock, Wishbone byte addresses on aligned 32-bit words
// Notes:   times are in ns, the cycle counts are derived from them
`ifndef NFC_DEFS_SVH
`define NFC_DEFS_SVH

// register byte offsets
`define NFC_REG_CTRL     6'h00
`define NFC_REG_CFG      6'h04
`define NFC_REG_ADDR     6'h08
`define NFC_REG_WDATA    6'h0C
`define NFC_REG_RDATA    6'h10
`define NFC_REG_STATUS   6'h14

// control register: operation code in bits 1:0
`define NFC_OP_NONE      2'h0
`define NFC_OP_READ      2'h1
`define NFC_OP_WRITE     2'h2
`define NFC_OP_RESET     2'h3

// configuration: bit 0 selects word-wide mode
`define NFC_CFG_WORD_BIT 0
`define NFC_CFG_RESET    1'h1

// status register field positions
`define NFC_ST_BUSY      0
`define NFC_ST_READY     1
`define NFC_ST_TOGGLE    2
`define NFC_ST_ALTTOG    3
`define NFC_ST_FAIL      4
`define NFC_ST_ABORT     5
`define NFC_ST_REFUSED   6
`define NFC_ST_DONE      7
`define NFC_ST_OPST_LSB  8
`define NFC_ST_BLK_LSB   16

// device status byte: positions and the mask of defined bits
`define NFC_DQ_TOGGLE    6
`define NFC_DQ_FAIL      5
`define NFC_DQ_ALTTOG    2
`define NFC_DQ_ABORT     1
`define NFC_OPST_MASK    8'hEE

// command byte that returns the device to read mode
`define NFC_CMD_RESET    8'hF0

// geometry: byte address 25 bits, block is 128KB / 64KW
`define NFC_ADDR_W       24
`define NFC_BADDR_W      25
`define NFC_BLK_BYTE_LSB 17
`define NFC_BLK_WORD_LSB 16

// timing (ns) and derived cycle counts, least times rounded up
`define NFC_CLK_NS       50
`define NFC_T_SETUP_NS   50
`define NFC_T_ACC_NS     80
`define NFC_T_WP_NS      50
`define NFC_T_HOLD_NS    50
`define NFC_T_REC_NS     50
`define NFC_T_RSTLOW_NS  10000
`define NFC_T_RHEL_NS    50000
`define NFC_SYNC_CYC     2
`define NFC_CYC(ns)      (((ns) + `NFC_CLK_NS - 1) / `NFC_CLK_NS)

`endif

// file: shared/nfc_pkg.sv
// Purpose: types shared by the flash bus controller
// Assumes: constants live in nfc_defs.svh
// Notes:   gray codes along read/write path
`default_nettype none
package nfc_pkg;
  typedef enum logic [2:0] {
    NFC_IDLE    = 3'h0,  // waiting for an order
    NFC_SETUP   = 3'h1,  // address and select settle
    NFC_STROBE  = 3'h3,  // output or write strobe low
    NFC_HOLD    = 3'h2,  // strobe high, data held
    NFC_RECOVER = 3'h6,  // deselected gap
    NFC_RST_LOW = 3'h4,  // reset pin low
    NFC_RST_WT  = 3'h5   // wait after reset release
  } nfc_state_e;
  typedef logic [11:0] nfc_count_t;  // phase counter width
endpackage
`default_nettype wire

// file: design/nfc_phase_timer.sv
// Purpose: down counter that times one bus phase
// Assumes: load value is at least one cycle
// Notes:   expired is high in the last cycle of a phase and while the timer idles
`default_nettype none
module nfc_phase_timer (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire logic              load,
  input  wire nfc_pkg::nfc_count_t load_val,
  output logic                   expired
);
  nfc_pkg::nfc_count_t cnt_r;    // cycles left in the phase
  nfc_pkg::nfc_count_t cnt_nxt;

  // next count: reload, or count down and stop at zero
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = load_val - 12'h001;
    end else if (cnt_r != 12'h000) begin
      cnt_nxt = cnt_r - 12'h001;
    end
  end

  // register, frozen while the clock enable is low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= 12'h000;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
    end
  end

  // flop-only source: the engine derives load from expired, so no load term here
  assign expired = (cnt_r == 12'h000);
endmodule
`default_nettype wire

// file: design/nfc_ctrl.sv
// Purpose: host controller driving a parallel flash's asynchronous bus from Wishbone registers
// Assumes: flash pins are plain input/output/enable signals, pull-up on ready_busy_n outside
// Notes:   every read is a random access; page mode is never used
// Operation
// - read: select and output enable low, write high
// - output enable stays high through writes
// - after failure send reset command first
// - buffer abort needs abort-reset command; here the F0 reset command clears it as well
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`default_nettype none
`include "nfc_defs.svh"
module nfc_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [5:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  output logic [23:0]      flash_addr,
  output logic [14:0]      flash_dq_out,
  input  wire logic [14:0] flash_dq_in,
  output logic             flash_dq_oe,
  output logic             low_addr_or_d15_out,
  input  wire logic        low_addr_or_d15_in,
  output logic             low_addr_or_d15_oe,
  output logic             chip_select_n,
  output logic             output_enable_n,
  output logic             write_strobe_n,
  output logic             hw_reset_n,
  output logic             width_select_n,
  input  wire logic        ready_busy_n
);
  // block index of an address, byte or word mode
  function automatic logic [7:0] blk_of(input logic [24:0] a, input logic word);
    blk_of = word ? a[`NFC_BLK_WORD_LSB +: 8] : a[`NFC_BLK_BYTE_LSB +: 8];
  endfunction
  // cycle count of a time, cut to counter width
  function automatic nfc_pkg::nfc_count_t cyc(input int ns);
    cyc = nfc_pkg::nfc_count_t'(`NFC_CYC(ns));
  endfunction

  // pin synchronisers: two flops before any logic
  logic [15:0] dq_s1_r;          // first stage, read by second only
  logic [15:0] dq_s2_r;          // data usable by logic
  logic        rb_s1_r;
  logic        rb_s2_r;          // ready busy usable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
      rb_s1_r <= 1'h1;
      rb_s2_r <= 1'h1;
    end else if (clk_en) begin
      dq_s1_r <= {low_addr_or_d15_in, flash_dq_in};
      dq_s2_r <= dq_s1_r;
      rb_s1_r <= ready_busy_n;
      rb_s2_r <= rb_s1_r;
    end
  end

  // bus group: registers software writes
  logic        ack_r, ack_nxt;
  logic [31:0] rd_r, rd_nxt;      // read data word
  logic        word_r, word_nxt;  // word-wide mode
  logic [24:0] addr_r, addr_nxt;  // byte address, or word address
  logic [15:0] wd_r, wd_nxt;      // write data
  logic [1:0]  op_r, op_nxt;      // pending operation
  logic        start_r, start_nxt;  // one-cycle launch
  logic        refused_r, refused_nxt;
  // engine group
  nfc_pkg::nfc_state_e st_r, st_nxt;
  logic        busy_r, busy_nxt;
  logic        done_r, done_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        tog_r, tog_nxt;     // toggle seen on last read
  logic        alt_r, alt_nxt;     // alt toggle seen
  logic        fail_r, fail_nxt;   // failure pending reset
  logic        abort_r, abort_nxt; // buffer abort pending reset
  logic [23:0] pa_r, pa_nxt;
  logic [14:0] pdo_r, pdo_nxt;
  logic        poe_r, poe_nxt;
  logic        d15o_r, d15o_nxt;
  logic        d15oe_r, d15oe_nxt;
  logic        cs_r, cs_nxt, oe_r, oe_nxt, we_r, we_nxt, rn_r, rn_nxt, ws_r, ws_nxt;
  logic        tmr_load;
  nfc_pkg::nfc_count_t tmr_val;
  logic        tmr_exp;
  logic        hit;              // bus request this cycle
  logic        gate_bad;         // write blocked by pending error
  logic [15:0] status_w;

  assign hit = wb_cyc && wb_stb && !ack_r;
  assign gate_bad = (fail_r || abort_r) && (wd_r[7:0] != `NFC_CMD_RESET);

  always_comb begin
    status_w = 16'h0000;
    status_w[`NFC_ST_BUSY]    = busy_r;
    status_w[`NFC_ST_READY]   = rb_s2_r;
    status_w[`NFC_ST_TOGGLE]  = tog_r;
    status_w[`NFC_ST_ALTTOG]  = alt_r;
    status_w[`NFC_ST_FAIL]    = fail_r;
    status_w[`NFC_ST_ABORT]   = abort_r;
    status_w[`NFC_ST_REFUSED] = refused_r;
    status_w[`NFC_ST_DONE]    = done_r;
    // poll, erase timer and other defined bits kept
    // undefined status bits masked out
    status_w[`NFC_ST_OPST_LSB +: 8] = rdata_r[7:0] & `NFC_OPST_MASK;
  end

  // bus slave: single-wait ack, unmapped reads zero
  always_comb begin
    ack_nxt = hit;
    rd_nxt = rd_r;
    word_nxt = word_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    op_nxt = op_r;
    start_nxt = 1'h0;
    refused_nxt = refused_r;
    if (hit && wb_we) begin
      if (wb_adr == `NFC_REG_CTRL && wb_sel[0]) begin
        // orders while busy, or blocked writes, are refused
        if (busy_r || start_r || wb_dat_w[1:0] == `NFC_OP_NONE ||
            (wb_dat_w[1:0] == `NFC_OP_WRITE && gate_bad)) begin
          refused_nxt = 1'h1;
        end else begin
          op_nxt = wb_dat_w[1:0];
          start_nxt = 1'h1;
          refused_nxt = 1'h0;
        end
      end else if (wb_adr == `NFC_REG_CFG && wb_sel[0]) begin
        if (!busy_r) begin
          word_nxt = wb_dat_w[`NFC_CFG_WORD_BIT];
        end
      end else if (wb_adr == `NFC_REG_ADDR) begin
        if (wb_sel[0]) addr_nxt[7:0] = wb_dat_w[7:0];
        if (wb_sel[1]) addr_nxt[15:8] = wb_dat_w[15:8];
        if (wb_sel[2]) addr_nxt[23:16] = wb_dat_w[23:16];
        if (wb_sel[3]) addr_nxt[24] = wb_dat_w[24];
      end else if (wb_adr == `NFC_REG_WDATA) begin
        if (wb_sel[0]) wd_nxt[7:0] = wb_dat_w[7:0];
        if (wb_sel[1]) wd_nxt[15:8] = wb_dat_w[15:8];
      end
    end
    if (hit && !wb_we) begin
      if (wb_adr == `NFC_REG_CTRL) begin
        rd_nxt = {30'h0, op_r};
      end else if (wb_adr == `NFC_REG_CFG) begin
        rd_nxt = {31'h0, word_r};
      end else if (wb_adr == `NFC_REG_ADDR) begin
        rd_nxt = {7'h0, addr_r};
      end else if (wb_adr == `NFC_REG_WDATA) begin
        rd_nxt = {16'h0, wd_r};
      end else if (wb_adr == `NFC_REG_RDATA) begin
        rd_nxt = {16'h0, rdata_r};
      end else if (wb_adr == `NFC_REG_STATUS) begin
        rd_nxt = {8'h0, blk_of(addr_r, word_r), status_w};
      end else begin
        rd_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_r <= 1'h0;
      rd_r <= 32'h0000_0000;
      word_r <= `NFC_CFG_RESET;
      addr_r <= 25'h000_0000;
      wd_r <= 16'h0000;
      op_r <= `NFC_OP_NONE;
      start_r <= 1'h0;
      refused_r <= 1'h0;
    end else if (clk_en) begin
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
      word_r <= word_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      op_r <= op_nxt;
      start_r <= start_nxt;
      refused_r <= refused_nxt;
    end
  end

  // engine: one bus cycle per read or write order, reset order pulses the pin; phases of whole 50ns cycles
  always_comb begin
    st_nxt = st_r;
    busy_nxt = busy_r;
    done_nxt = done_r;
    rdata_nxt = rdata_r;
    tog_nxt = tog_r;
    alt_nxt = alt_r;
    fail_nxt = fail_r;
    abort_nxt = abort_r;
    pa_nxt = pa_r;
    pdo_nxt = pdo_r;
    poe_nxt = poe_r;
    d15o_nxt = d15o_r;
    d15oe_nxt = d15oe_r;
    cs_nxt = cs_r;
    oe_nxt = oe_r;
    we_nxt = we_r;
    rn_nxt = rn_r;
    ws_nxt = word_r;                   // high pin selects word mode
    tmr_load = 1'h0;
    tmr_val = 12'h001;
    case (st_r)
      nfc_pkg::NFC_IDLE: begin
        if (start_r && op_r == `NFC_OP_RESET) begin
          busy_nxt = 1'h1;
          done_nxt = 1'h0;
          rn_nxt = 1'h0;               // strobes stay high
          st_nxt = nfc_pkg::NFC_RST_LOW;
          tmr_load = 1'h1;
          tmr_val = cyc(`NFC_T_RSTLOW_NS);
        end else if (start_r) begin
          busy_nxt = 1'h1;
          done_nxt = 1'h0;
          // byte mode: pin carries the lowest address bit
          pa_nxt = word_r ? addr_r[23:0] : addr_r[24:1];
          d15o_nxt = word_r ? wd_r[15] : addr_r[0];
          d15oe_nxt = !word_r || (op_r == `NFC_OP_WRITE);
          pdo_nxt = wd_r[14:0];
          poe_nxt = (op_r == `NFC_OP_WRITE);  // drive only with output enable high
          cs_nxt = 1'h0;               // address settles before any strobe
          oe_nxt = 1'h1;
          we_nxt = 1'h1;
          st_nxt = nfc_pkg::NFC_SETUP;
          tmr_load = 1'h1;
          tmr_val = cyc(`NFC_T_SETUP_NS);
        end
      end
      nfc_pkg::NFC_SETUP: begin
        if (tmr_exp) begin
          tmr_load = 1'h1;
          st_nxt = nfc_pkg::NFC_STROBE;
          if (op_r == `NFC_OP_READ) begin
            oe_nxt = 1'h0;             // read strobe
            // random access time always
            tmr_val = cyc(`NFC_T_ACC_NS) + 12'(`NFC_SYNC_CYC);
          end else begin
            we_nxt = 1'h0;             // output enable kept high
            tmr_val = cyc(`NFC_T_WP_NS);
          end
        end
      end
      nfc_pkg::NFC_STROBE: begin
        if (tmr_exp) begin
          tmr_load = 1'h1;
          tmr_val = cyc(`NFC_T_HOLD_NS);
          st_nxt = nfc_pkg::NFC_HOLD;
          if (op_r == `NFC_OP_READ) begin
            rdata_nxt = word_r ? dq_s2_r : {8'h00, dq_s2_r[7:0]};
            // busy device answers status on the low byte
            tog_nxt = dq_s2_r[`NFC_DQ_TOGGLE] != rdata_r[`NFC_DQ_TOGGLE];
            alt_nxt = dq_s2_r[`NFC_DQ_ALTTOG] != rdata_r[`NFC_DQ_ALTTOG];
            if (tog_nxt && dq_s2_r[`NFC_DQ_FAIL]) begin
              fail_nxt = 1'h1;
            end
            if (tog_nxt && dq_s2_r[`NFC_DQ_ABORT]) begin
              abort_nxt = 1'h1;
            end
            oe_nxt = 1'h1;
            cs_nxt = 1'h1;             // deselect, device floats
          end else begin
            we_nxt = 1'h1;             // data held past rising strobe
          end
        end
      end
      nfc_pkg::NFC_HOLD: begin
        if (tmr_exp) begin
          cs_nxt = 1'h1;
          poe_nxt = 1'h0;
          d15oe_nxt = !word_r;
          if (op_r == `NFC_OP_WRITE && wd_r[7:0] == `NFC_CMD_RESET) begin
            fail_nxt = 1'h0;           // reset command sent
            abort_nxt = 1'h0;
          end
          st_nxt = nfc_pkg::NFC_RECOVER;
          tmr_load = 1'h1;
          tmr_val = cyc(`NFC_T_REC_NS);
        end
      end
      nfc_pkg::NFC_RECOVER: begin
        if (tmr_exp) begin
          busy_nxt = 1'h0;
          done_nxt = 1'h1;
          st_nxt = nfc_pkg::NFC_IDLE;
        end
      end
      nfc_pkg::NFC_RST_LOW: begin
        if (tmr_exp) begin
          rn_nxt = 1'h1;
          st_nxt = nfc_pkg::NFC_RST_WT;
          tmr_load = 1'h1;
          tmr_val = cyc(`NFC_T_RHEL_NS);
        end
      end
      nfc_pkg::NFC_RST_WT: begin
        // no access until ready busy released
        if (tmr_exp && rb_s2_r) begin
          busy_nxt = 1'h0;
          done_nxt = 1'h1;
          fail_nxt = 1'h0;
          abort_nxt = 1'h0;
          st_nxt = nfc_pkg::NFC_IDLE;
        end
      end
      default: begin
        st_nxt = nfc_pkg::NFC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= nfc_pkg::NFC_IDLE;
      busy_r <= 1'h0;
      done_r <= 1'h0;
      rdata_r <= 16'h0000;
      tog_r <= 1'h0;
      alt_r <= 1'h0;
      fail_r <= 1'h0;
      abort_r <= 1'h0;
      pa_r <= 24'h00_0000;
      pdo_r <= 15'h0000;
      poe_r <= 1'h0;
      d15o_r <= 1'h0;
      d15oe_r <= 1'h0;
      cs_r <= 1'h1;
      oe_r <= 1'h1;
      we_r <= 1'h1;
      rn_r <= 1'h1;
      ws_r <= `NFC_CFG_RESET;
    end else if (clk_en) begin
      st_r <= st_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      tog_r <= tog_nxt;
      alt_r <= alt_nxt;
      fail_r <= fail_nxt;
      abort_r <= abort_nxt;
      pa_r <= pa_nxt;
      pdo_r <= pdo_nxt;
      poe_r <= poe_nxt;
      d15o_r <= d15o_nxt;
      d15oe_r <= d15oe_nxt;
      cs_r <= cs_nxt;
      oe_r <= oe_nxt;
      we_r <= we_nxt;
      rn_r <= rn_nxt;
      ws_r <= ws_nxt;
    end
  end

  nfc_phase_timer u_timer (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .clk_en   (clk_en),
    .load     (tmr_load && clk_en),
    .load_val (tmr_val),
    .expired  (tmr_exp)
  );

  assign wb_dat_r = rd_r;
  assign wb_ack = ack_r;
  assign flash_addr = pa_r;
  assign flash_dq_out = pdo_r;
  assign flash_dq_oe = poe_r;
  assign low_addr_or_d15_out = d15o_r;
  assign low_addr_or_d15_oe = d15oe_r;
  assign chip_select_n = cs_r;
  assign output_enable_n = oe_r;
  assign write_strobe_n = we_r;
  assign hw_reset_n = rn_r;
  assign width_select_n = ws_r;

  a_read_strobe_sel: assert property (@(posedge clk_sys) disable iff (rst)
    !output_enable_n |-> !chip_select_n && write_strobe_n && !flash_dq_oe)
    else $error("read strobe without select or with write");
  a_write_oe_high: assert property (@(posedge clk_sys) disable iff (rst)
    (!write_strobe_n || flash_dq_oe) |-> output_enable_n)
    else $error("output enable low during write");
  a_write_addr_hold: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(write_strobe_n) |-> $stable(flash_addr) && $past(!chip_select_n))
    else $error("address not settled before write strobe");
  a_write_data_hold: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(write_strobe_n) |-> flash_dq_oe && !chip_select_n && $stable(flash_dq_out))
    else $error("write data released at strobe rise");
  a_error_cmd_gate: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(write_strobe_n) && (fail_r || abort_r) |-> flash_dq_out[7:0] == `NFC_CMD_RESET)
    else $error("command sent while error pending");
  a_reset_quiet_bus: assert property (@(posedge clk_sys) disable iff (rst)
    !hw_reset_n |-> chip_select_n && output_enable_n && write_strobe_n)
    else $error("strobes active during reset");
endmodule
`default_nettype wire

// file: design/nfc_fix_note.sv
// Purpose: none
// Assumes: none
// Notes:   intentionally empty
`default_nettype none
`default_nettype wire

// file: test/nfc_flash_model.sv
// Purpose: behavioural flash device on the far side of the controller
// Assumes: F0 read mode, 77 a failing op, 66 an aborted buffer op, others a short busy op
// Notes:   released data lines show the inverse of the last value
`default_nettype none
module nfc_flash_model (
  input  wire logic [23:0] a,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rst_n,
  input  wire logic        byte_n,
  output logic             rb_n,
  output logic      [7:0]  cmd,
  output logic      [23:0] la,
  output int               bad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] last = 16'h0000;  // last value driven
  logic [1:0]  mode = 2'h0;      // 0 array, 1 busy, 2 failed, 3 aborted
  logic        tog = 1'b0;       // toggle state
  logic        rd_on = 1'b0;     // read under way
  int          left = 0;         // busy reads to go
  logic [15:0] rd;               // what a read shows
  logic        drv;              // device drives data
  initial begin
    bad = 0;
    cmd = 8'h00;
    la = 24'h000000;
  end
  // status byte while working, else an address pattern
  always @* begin
    if (mode != 2'h0)
      rd = {8'h00, ~cmd[7], tog, mode == 2'h2, 3'h0, mode == 2'h3, 1'b0};
    else if (!byte_n)
      rd = {8'h00, {a[6:0], dq_i[15]} ^ 8'h5A};
    else
      rd = a[15:0] ^ 16'hC3A5;
  end
  assign drv = rst_n && !ce_n && !oe_n;
  assign dq_o[15:8] = (drv && byte_n) ? rd[15:8] : ~last[15:8];
  assign dq_o[7:0] = drv ? rd[7:0] : ~last[7:0];
  assign rb_n = (mode != 2'h1);
  // address at the later falling strobe
  always @(negedge ce_n or negedge we_n)
    if (!ce_n && !we_n && rst_n)
      la = a;
  // data at the earlier rising strobe
  always @(posedge ce_n or posedge we_n)
    if ((ce_n ^ we_n) && rst_n) begin
      cmd = dq_i[7:0];
      bad += !oe_n;
      left = 4;
      if (dq_i[7:0] == 8'hF0)
        mode = 2'h0;
      else if (dq_i[7:0] == 8'h77)
        mode = 2'h2;
      else if (dq_i[7:0] == 8'h66)
        mode = 2'h3;
      else
        mode = 2'h1;
    end
  // ce and oe rise together, so a read is opened at oe fall
  always @(negedge oe_n)
    if (!ce_n && rst_n) begin
      rd_on = 1'b1;
      bad += !we_n;
    end
  always @(posedge oe_n)
    if (rd_on) begin
      rd_on = 1'b0;
      last = rd;
      tog = ~tog;
      left = left - 1;
      if (mode == 2'h1 && left == 0)
        mode = 2'h0;
    end
  always @(negedge rst_n) begin
    mode = 2'h0;
    rd_on = 1'b0;
  end
endmodule
`default_nettype wire

// file: test/nfc_ctrl_tb_top.sv
// Purpose: self-checking bench of the flash bus controller
// Assumes: pull-up on ready, flash model on the far side
// Notes:   one Wishbone master task; each scenario judges its results
`default_nettype none
`include "nfc_defs.svh"
module nfc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;      // request, stb follows it
  logic        we = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] dw = 32'h0;
  logic [31:0] q;               // last read data
  wire  [31:0] dr;
  wire  [23:0] fa;
  wire  [23:0] la;
  wire  [14:0] dqo;
  wire  [15:0] fdo;
  wire  [15:0] bus;             // resolved data wires
  wire  [7:0]  cmd;
  wire         ack, dqoe, d15o, d15oe, ce_n, oe_n, we_n, hr_n, ws_n, rb_n;
  int          bad;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc_n = 0;
  int          low_n = 0;
  assign bus = {d15oe ? d15o : fdo[15], dqoe ? dqo : fdo[14:0]};
  nfc_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .wb_cyc(cyc),
    .wb_stb(cyc), .wb_we(we), .wb_adr(adr), .wb_sel(4'hF), .wb_dat_w(dw),
    .wb_dat_r(dr), .wb_ack(ack), .flash_addr(fa), .flash_dq_out(dqo),
    .flash_dq_in(bus[14:0]), .flash_dq_oe(dqoe), .low_addr_or_d15_out(d15o),
    .low_addr_or_d15_in(bus[15]), .low_addr_or_d15_oe(d15oe),
    .chip_select_n(ce_n), .output_enable_n(oe_n), .write_strobe_n(we_n),
    .hw_reset_n(hr_n), .width_select_n(ws_n), .ready_busy_n(rb_n));
  nfc_flash_model flash_u (.a(fa), .dq_i(bus), .dq_o(fdo), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .rst_n(hr_n), .byte_n(ws_n), .rb_n(rb_n), .cmd(cmd), .la(la),
    .bad(bad));
  initial forever #25 clk_sys = ~clk_sys;
  // hang guard and reset pulse length
  always @(posedge clk_sys) begin
    cyc_n++;
    if (!hr_n)
      low_n++;
    if (cyc_n == 20000) begin
      n_fail++;
      test_done;
    end
  end
  task test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  // classic cycle: hold until ack is sampled, then release
  task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    do @(posedge clk_sys); while (ack !== 1'b1);
    q = dr;
    cyc <= 1'b0;
  endtask
  task rs(input logic [5:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  // start an operation and poll until done and idle
  task op(input logic [1:0] c);
    int i;
    wb(1'b1, `NFC_REG_CTRL, {30'h0, c});
    q = 32'h0;
    for (i = 0; i < 3000 && !(q[7] === 1'b1 && q[0] === 1'b0); i++)
      rs(`NFC_REG_STATUS);
    chk("op_done", {q[7], q[0]}, 2'b10);
  endtask
  task t_idle;
    chk("pins", {ce_n, oe_n, we_n, hr_n, dqoe}, 5'b11110);
    chk("width", ws_n, 1'b1);
    rs(`NFC_REG_CFG);
    chk("cfg", q, 32'h1);
    wb(1'b1, 6'h18, 32'hFFFF);
    rs(6'h18);
    chk("unmapped", q, 32'h0);
    rs(`NFC_REG_STATUS);
    chk("status", q, 32'h2);
  endtask
  task t_rword;
    wb(1'b1, `NFC_REG_ADDR, 32'h0FF0005);
    op(`NFC_OP_READ);
    chk("block", q[23:16], 8'hFF);
    rs(`NFC_REG_RDATA);
    chk("rdata", q, 32'hC3A0);
  endtask
  task t_prog;
    wb(1'b1, `NFC_REG_ADDR, 32'h0000AAA);
    wb(1'b1, `NFC_REG_WDATA, 32'h55);
    op(`NFC_OP_WRITE);
    chk("cmd", cmd, 8'h55);
    chk("cmd_addr", la, 24'h000AAA);
    chk("ready", q[1], 1'b0);
    op(`NFC_OP_READ);
    op(`NFC_OP_READ);
    chk("toggle", q[2], 1'b1);
    chk("poll", q[15:8], 8'h80);
    op(`NFC_OP_READ);
    op(`NFC_OP_READ);
    chk("ready2", q[1], 1'b1);
  endtask
  task t_fail;
    wb(1'b1, `NFC_REG_WDATA, 32'h77);
    op(`NFC_OP_WRITE);
    op(`NFC_OP_READ);
    op(`NFC_OP_READ);
    chk("fail", q[4], 1'b1);
    wb(1'b1, `NFC_REG_WDATA, 32'h55);
    wb(1'b1, `NFC_REG_CTRL, 32'h2);
    rs(`NFC_REG_STATUS);
    chk("refused", {q[6], cmd}, 9'h177);
    wb(1'b1, `NFC_REG_WDATA, {24'h0, `NFC_CMD_RESET});
    op(`NFC_OP_WRITE);
    chk("cleared", {q[4], cmd}, 9'h0F0);
  endtask
  task t_byte;
    wb(1'b1, `NFC_REG_CFG, 32'h0);
    wb(1'b1, `NFC_REG_ADDR, 32'h1FE0001);
    op(`NFC_OP_READ);
    chk("block_b", q[23:16], 8'hFF);
    chk("low_addr", {ws_n, d15oe, d15o}, 3'b011);
    rs(`NFC_REG_RDATA);
    chk("rdata_b", q, 32'h5B);
    wb(1'b1, `NFC_REG_CFG, 32'h1);
  endtask
  task t_hwrst;
    wb(1'b1, `NFC_REG_WDATA, 32'h66);
    op(`NFC_OP_WRITE);
    op(`NFC_OP_READ);
    chk("abort", q[5], 1'b1);
    low_n = 0;
    op(`NFC_OP_RESET);
    chk("rst_low", low_n, 200);
    chk("flags", q[5:4], 2'b00);
    op(`NFC_OP_READ);
    rs(`NFC_REG_RDATA);
    chk("after_rst", q, 32'hC3A4);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_idle;
    t_rword;
    t_prog;
    t_fail;
    t_byte;
    t_hwrst;
    chk("bus_rules", bad, 0);
    test_done;
  end
endmodule
`default_nettype wire
